// ==== rtl/ccr_pkg.sv ====
package ccr_pkg;
    // Ratio-select codes
    localparam logic [3:0] CCR_CODE_2X0  = 4'h4;
    localparam logic [3:0] CCR_CODE_2X5  = 4'h6;
    localparam logic [3:0] CCR_CODE_3X0  = 4'h8;
    localparam logic [3:0] CCR_CODE_3X5  = 4'he;
    localparam logic [3:0] CCR_CODE_4X0  = 4'ha;
    localparam logic [3:0] CCR_CODE_4X5  = 4'h7;
    localparam logic [3:0] CCR_CODE_5X0  = 4'hb;
    localparam logic [3:0] CCR_CODE_5X5  = 4'h9;
    localparam logic [3:0] CCR_CODE_6X0  = 4'hd;
    localparam logic [3:0] CCR_CODE_6X5  = 4'h5;
    localparam logic [3:0] CCR_CODE_7X0  = 4'h2;
    localparam logic [3:0] CCR_CODE_7X5  = 4'h1;
    localparam logic [3:0] CCR_CODE_8X0  = 4'hc;
    localparam logic [3:0] CCR_CODE_9X0  = 4'h0;
    localparam logic [3:0] CCR_CODE_BYP  = 4'h3;
    localparam logic [3:0] CCR_CODE_OFF  = 4'hf;
    // Bypass multiplier in half units (1x -> 2); VCO multiplier as plain VCO-to-core ratio
    localparam logic [4:0] CCR_HALF_BYP  = 5'h02;
    localparam logic [4:0] CCR_VCO_MUL   = 5'h02;
    // Register map (word offsets as byte addresses)
    localparam logic [3:0] CCR_ADDR_CTRL = 4'h0;
    localparam logic [3:0] CCR_ADDR_STAT = 4'h4;
    // Control register fields
    localparam int         CCR_DIV_LSB   = 0;
    localparam int         CCR_DIV_W     = 3;
    localparam int         CCR_EXT_BIT   = 8;
    localparam logic [2:0] CCR_DIV_RST   = 3'h1;
    // Status register fields
    localparam int         CCR_ST_HALF   = 0;
    localparam int         CCR_ST_BYP    = 8;
    localparam int         CCR_ST_OFF    = 9;
    localparam int         CCR_ST_RSVD   = 10;
    localparam int         CCR_ST_LOCK   = 11;
    localparam int         CCR_ST_CODE   = 12;
endpackage : ccr_pkg

// ==== rtl/ccr_core_clock_ratio_config.sv ====
// Notes on behaviour
// - Codes 0100,0110,1000,1110,1010 give 2x to 4x core multiplier, VCO twice core.
// - Codes 0111..0000 give 4.5x to 9x core multiplier, VCO twice core.
// - Code 0011 bypasses PLL; bus clock drives core at 1:1.
// - Code 1111 turns PLL off; no core clocking at all.
// - Cache clock is core clock divided by twice the control register divisor.
// - Delay-lock loop steps a tap on the delayed cache clock until it matches the feedback input, then reports lock; cache clock output is not delayed.
// - Address and data bus busy pins are outputs only, monitors in extended mode.
// - Legacy mode ignores extended-only inputs and three-states extended-only outputs.
// - Mode signal high at reset release for legacy, low for extended.
module ccr_core_clock_ratio_config
    import ccr_pkg::*;
#(
    parameter int DLL_TAPS = 8
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_ce,
    input  wire logic [3:0]  i_ratio_code,
    input  wire logic        i_sleep,
    input  wire logic        i_strap_extended_mode,
    input  wire logic        i_cache2_feedback_clk_in,
    input  wire logic        i_machine_check_n,
    input  wire logic        i_ext_only_in,
    input  wire logic        i_addr_busy_n,
    input  wire logic        i_data_busy_n,
    input  wire logic        i_addr_activity,
    input  wire logic        i_data_activity,
    input  wire logic        i_ext_only_out,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [3:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    output logic      [4:0]  o_core_half_mult,
    output logic      [4:0]  o_vco_mult,
    output logic             o_pll_enable,
    output logic             o_core_clock_en,
    output logic             o_bypass,
    output logic             o_cache2_clk,
    output logic             o_cache2_feedback_clk_out,
    output logic             o_dll_locked,
    output logic             o_machine_check,
    output logic             o_addr_bus_busy_n,
    output logic             o_data_bus_busy_n,
    output logic             o_busy_oe,
    output logic             o_ext_only_in_q,
    output logic             o_ext_only_out,
    output logic             o_ext_only_oe,
    output logic             o_mode_n,
    output logic             o_extended_bus_mode
);
    localparam int TW = $clog2(DLL_TAPS);

    typedef struct packed {
        logic [3:0]           code;
        logic [4:0]           half;
        logic                 byp;
        logic                 off;
        logic                 rsvd;
        logic                 ext;
        logic [CCR_DIV_W-1:0] div;
        logic [CCR_DIV_W-1:0] cnt;
        logic                 cclk;
        logic [TW-1:0]        tap;
        logic [DLL_TAPS-1:0]  dly;
        logic                 fb_q;
        logic                 locked;
        logic [1:0]           mcp_sh;
        logic                 machine_check_n;
        logic                 ack;
        logic [31:0]          rdat;
        logic                 ext_in_q;
    } ccr_state_t;

    ccr_state_t s;
    ccr_state_t next_s;

    // ==========================================
    // Ratio decode
    function automatic logic [4:0] ccr_decode(input logic [3:0] c);
        unique case (c)
            CCR_CODE_2X0: ccr_decode = 5'h04;
            CCR_CODE_2X5: ccr_decode = 5'h05;
            CCR_CODE_3X0: ccr_decode = 5'h06;
            CCR_CODE_3X5: ccr_decode = 5'h07;
            CCR_CODE_4X0: ccr_decode = 5'h08;
            CCR_CODE_4X5: ccr_decode = 5'h09;
            CCR_CODE_5X0: ccr_decode = 5'h0a;
            CCR_CODE_5X5: ccr_decode = 5'h0b;
            CCR_CODE_6X0: ccr_decode = 5'h0c;
            CCR_CODE_6X5: ccr_decode = 5'h0d;
            CCR_CODE_7X0: ccr_decode = 5'h0e;
            CCR_CODE_7X5: ccr_decode = 5'h0f;
            CCR_CODE_8X0: ccr_decode = 5'h10;
            CCR_CODE_9X0: ccr_decode = 5'h12;
            CCR_CODE_BYP: ccr_decode = CCR_HALF_BYP;
            default:      ccr_decode = 5'h00;
        endcase
    endfunction

    logic is_listed;
    assign is_listed = (i_ratio_code == CCR_CODE_BYP) || (i_ratio_code == CCR_CODE_OFF)
                       || (ccr_decode(i_ratio_code) != 5'h00);

    // ==========================================
    // Next state
    always_comb begin
        next_s = s;
        // Code sampled only in reset or sleep; otherwise held
        if (i_sleep) begin
            next_s.code = i_ratio_code;
            next_s.half = ccr_decode(i_ratio_code);
            next_s.byp  = (i_ratio_code == CCR_CODE_BYP);
            next_s.off  = (i_ratio_code == CCR_CODE_OFF);
            next_s.rsvd = !is_listed;
        end
        // Cache clock divider; divisor zero stops the clock
        if (s.off || s.div == '0) begin
            next_s.cnt  = '0;
            next_s.cclk = 1'b0;
        end else if (s.cnt >= s.div - 3'h1) begin
            next_s.cnt  = '0;
            next_s.cclk = ~s.cclk;
        end else begin
            next_s.cnt  = s.cnt + 3'h1;
        end
        // DLL: delay line, tap steps until feedback matches
        next_s.dly  = {s.dly[DLL_TAPS-2:0], s.cclk};
        next_s.fb_q = i_cache2_feedback_clk_in;
        next_s.locked = 1'b0;
        if (s.cclk && !s.fb_q && i_cache2_feedback_clk_in) begin
            next_s.locked = (s.dly[s.tap] == i_cache2_feedback_clk_in) ? 1'b1 : 1'b0;
        end else begin
            next_s.locked = s.locked;
        end
        if (!s.locked && s.cclk && !s.fb_q && i_cache2_feedback_clk_in) begin
            next_s.tap = (s.tap == TW'(DLL_TAPS - 1)) ? '0 : s.tap + TW'(1);
        end
        // Machine check: two consecutive low samples
        next_s.mcp_sh = {s.mcp_sh[0], ~i_machine_check_n};
        next_s.machine_check_n    = s.mcp_sh[1] & s.mcp_sh[0];
        // Extended-only input ignored in legacy mode
        next_s.ext_in_q = s.ext ? i_ext_only_in : 1'b0;
        // Wishbone slave, one wait state
        next_s.ack = i_wb_cyc && i_wb_stb && !s.ack;
        if (i_wb_cyc && i_wb_stb && !s.ack) begin
            next_s.rdat = '0;
            if (i_wb_adr == CCR_ADDR_CTRL) begin
                next_s.rdat[CCR_DIV_LSB +: CCR_DIV_W] = s.div;
                if (i_wb_we && i_wb_sel[0]) begin
                    next_s.div = i_wb_dat[CCR_DIV_LSB +: CCR_DIV_W];
                end
            end else if (i_wb_adr == CCR_ADDR_STAT) begin
                next_s.rdat[CCR_ST_HALF +: 5]  = s.half;
                next_s.rdat[CCR_ST_BYP]        = s.byp;
                next_s.rdat[CCR_ST_OFF]        = s.off;
                next_s.rdat[CCR_ST_RSVD]       = s.rsvd;
                next_s.rdat[CCR_ST_LOCK]       = s.locked;
                next_s.rdat[CCR_ST_CODE +: 4]  = s.code;
                next_s.rdat[CCR_EXT_BIT + 8]   = s.ext;
            end
        end
    end

    // ==========================================
    // State register; hard reset also captures straps
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            s        <= '0;
            s.div    <= CCR_DIV_RST;
            // Straps land in the held state, so code and mode survive release
            s.code   <= i_ratio_code;
            s.half   <= ccr_decode(i_ratio_code);
            s.byp    <= (i_ratio_code == CCR_CODE_BYP);
            s.off    <= (i_ratio_code == CCR_CODE_OFF);
            s.rsvd   <= !is_listed;
            s.ext    <= i_strap_extended_mode;
        end else if (i_ce) begin
            s <= next_s;
        end
    end

    // Straps caught by a clocked process while reset is held
    logic [3:0] strap_code;
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            strap_code <= i_ratio_code;
        end
    end

    logic first;
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            first <= 1'b1;
        end else if (i_ce) begin
            first <= 1'b0;
        end
    end

    logic [3:0] eff_code;
    assign eff_code = first ? strap_code : s.code;

    // ==========================================
    // Outputs
    assign o_wb_ack                  = s.ack;
    assign o_wb_dat                  = s.rdat;
    assign o_core_half_mult          = first ? ccr_decode(eff_code) : s.half;
    assign o_vco_mult                = (eff_code == CCR_CODE_OFF || eff_code == CCR_CODE_BYP) ? 5'h00 : CCR_VCO_MUL;
    assign o_pll_enable              = !(eff_code == CCR_CODE_OFF || eff_code == CCR_CODE_BYP);
    assign o_core_clock_en           = (eff_code != CCR_CODE_OFF);
    assign o_bypass                  = (eff_code == CCR_CODE_BYP);
    assign o_cache2_clk              = s.cclk;
    assign o_cache2_feedback_clk_out = s.cclk;
    assign o_dll_locked              = s.locked;
    assign o_machine_check           = s.machine_check_n;
    // Busy pins: output-only, monitors in extended mode
    assign o_addr_bus_busy_n         = s.ext ? ~i_addr_activity : i_addr_busy_n;
    assign o_data_bus_busy_n         = s.ext ? ~i_data_activity : i_data_busy_n;
    assign o_busy_oe                 = 1'b1;
    assign o_ext_only_in_q           = s.ext_in_q;
    assign o_ext_only_out            = s.ext ? i_ext_only_out : 1'b0;
    assign o_ext_only_oe             = s.ext;
    assign o_mode_n                  = ~s.ext;
    assign o_extended_bus_mode       = s.ext;

    // ==========================================
    // Assertions
    AST_PLL_OFF: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (eff_code == CCR_CODE_OFF) |-> (!o_core_clock_en && !o_pll_enable))
        else $error("pll off still clocks");
    AST_BYPASS: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        o_bypass |-> (o_core_half_mult == CCR_HALF_BYP && !o_pll_enable))
        else $error("bypass not 1:1");
    AST_VCO: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        o_pll_enable |-> (o_vco_mult == CCR_VCO_MUL))
        else $error("vco not twice core");
    AST_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_b || first)
        (i_ce && !i_sleep) |=> $stable(s.code))
        else $error("code changed in operation");
    AST_MCP: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_ce && !i_machine_check_n) [*2] ##1 i_ce |=> o_machine_check)
        else $error("machine check missed");
    AST_LEGACY_OE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !s.ext |-> (!o_ext_only_oe && o_mode_n))
        else $error("legacy drives ext output");
    AST_BUSY_OUT: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        o_busy_oe)
        else $error("busy pins not driven");
    AST_DIV_ZERO: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (s.div == '0 && i_ce) [*2] |-> !o_cache2_clk)
        else $error("divider zero runs");
    AST_FB: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        o_cache2_feedback_clk_out == o_cache2_clk)
        else $error("feedback clock mismatch");
    AST_MODE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        o_mode_n != o_extended_bus_mode)
        else $error("mode pin wrong");
    AST_DECODE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (!first && s.code == CCR_CODE_9X0) |-> (o_core_half_mult == 5'h12))
        else $error("9x decode wrong");
endmodule : ccr_core_clock_ratio_config

// ==== tb/ccr_board_model.sv ====
module ccr_board_model (
    input  wire logic       i_clk,
    input  wire logic       i_cache2_feedback_clk_out,
    output logic      [3:0] o_ratio_code,
    output logic            o_sleep,
    output logic            o_machine_check_n,
    output logic            o_cache2_feedback_clk_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Straps and returned feedback clock
    // ==========================================
    initial begin
        o_ratio_code      = 4'h4;
        o_sleep           = 1'b0;
        o_machine_check_n = 1'b1;
    end
    // Trace returns the feedback clock unchanged
    assign o_cache2_feedback_clk_in = i_cache2_feedback_clk_out;
    // Code moves only while sleep is held, so the held code is reloaded
    task automatic apply_code(input logic [3:0] code);
        @(posedge i_clk);
        o_sleep      <= 1'b1;
        o_ratio_code <= code;
        repeat (2) @(posedge i_clk);
        o_sleep <= 1'b0;
    endtask
    task automatic pulse_mcp(input int n);
        @(posedge i_clk);
        o_machine_check_n <= 1'b0;
        repeat (n) @(posedge i_clk);
        o_machine_check_n <= 1'b1;
    endtask
endmodule // ccr_board_model

// ==== tb/core_clock_ratio_config_tb_top.sv ====
module core_clock_ratio_config_tb_top;
    import ccr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk, i_rst_b, i_wb_cyc, i_wb_stb, i_wb_we, i_addr_busy_n, i_data_busy_n, i_ext_only_in, i_ext_only_out;
    logic [3:0] i_wb_adr, i_wb_sel, code;
    logic [31:0] i_wb_dat, o_wb_dat, rd;
    logic o_wb_ack, o_pll_enable, o_core_clock_en, o_bypass, o_cache2_clk, fb_out, fb_in, o_dll_locked;
    logic o_machine_check, o_addr_bus_busy_n, o_data_bus_busy_n, o_busy_oe, o_ext_only_in_q, o_ext_only_out;
    logic o_ext_only_oe, o_mode_n, o_extended_bus_mode, sleep, mcp_n;
    logic ce, ext_strap, act_a, act_d;
    logic [4:0] o_core_half_mult, o_vco_mult;
    int failures = 0;
    int checks = 0;
    // Half-unit multiplier per code 0..f
    int half_tab [16] = '{18, 15, 14, 2, 4, 13, 5, 9, 6, 11, 8, 10, 16, 12, 7, 0};
    ccr_core_clock_ratio_config u_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(ce), .i_ratio_code(code),
        .i_sleep(sleep), .i_strap_extended_mode(ext_strap), .i_cache2_feedback_clk_in(fb_in),
        .i_machine_check_n(mcp_n), .i_ext_only_in(i_ext_only_in), .i_addr_busy_n(i_addr_busy_n),
        .i_data_busy_n(i_data_busy_n), .i_addr_activity(act_a), .i_data_activity(act_d),
        .i_ext_only_out(i_ext_only_out), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
        .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
        .o_core_half_mult(o_core_half_mult), .o_vco_mult(o_vco_mult), .o_pll_enable(o_pll_enable),
        .o_core_clock_en(o_core_clock_en), .o_bypass(o_bypass), .o_cache2_clk(o_cache2_clk),
        .o_cache2_feedback_clk_out(fb_out), .o_dll_locked(o_dll_locked), .o_machine_check(o_machine_check),
        .o_addr_bus_busy_n(o_addr_bus_busy_n), .o_data_bus_busy_n(o_data_bus_busy_n), .o_busy_oe(o_busy_oe),
        .o_ext_only_in_q(o_ext_only_in_q), .o_ext_only_out(o_ext_only_out), .o_ext_only_oe(o_ext_only_oe),
        .o_mode_n(o_mode_n), .o_extended_bus_mode(o_extended_bus_mode));
    ccr_board_model u_board (.i_clk(i_clk), .i_cache2_feedback_clk_out(fb_out), .o_ratio_code(code),
        .o_sleep(sleep), .o_machine_check_n(mcp_n), .o_cache2_feedback_clk_in(fb_in));
    // ==========================================
    // Shared tasks
    // ==========================================
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wait_for(ref logic sig, input logic val, input int bound);
        int n;
        for (n = 0; n < bound && sig !== val; n++) @(posedge i_clk);
        if (sig !== val) begin
            failures++;
            $display("FAIL timeout waiting");
            conclude();
        end
    endtask
    // Classic cycle; ack looked at before the edge's own updates land
    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
        int n;
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we  <= we;
        i_wb_adr <= adr;
        i_wb_sel <= 4'hf;
        i_wb_dat <= dat;
        for (n = 0; n < 20; n++) begin
            @(posedge i_clk);
            if (o_wb_ack === 1'b1) break;
        end
        if (o_wb_ack !== 1'b1) begin
            failures++;
            $display("FAIL timeout on bus");
            conclude();
        end
        rd = o_wb_dat;
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
        @(posedge i_clk);
    endtask
    // ==========================================
    // Scenarios
    // ==========================================
    task automatic test_codes();
        for (int c = 0; c < 16; c++) begin
            u_board.apply_code(4'(c));
            repeat (2) @(posedge i_clk);
            @(negedge i_clk);
            check("half_mult", 32'(o_core_half_mult), 32'(half_tab[c]));
            check("vco", 32'(o_vco_mult), (c == 3 || c == 15) ? 32'h0 : 32'h2);
            check("pll_en", 32'(o_pll_enable), 32'(c != 3 && c != 15));
            check("core_en", 32'(o_core_clock_en), 32'(c != 15));
            check("bypass", 32'(o_bypass), 32'(c == 3));
            @(posedge i_clk);
            wb(1'b0, CCR_ADDR_STAT, 32'h0);
            check("stat_half", 32'(rd[4:0]), 32'(half_tab[c]));
            check("stat_code", 32'(rd[15:12]), 32'(c));
        end
        $display("test codes done");
    endtask
    task automatic test_cache_clock();
        int n;
        u_board.apply_code(4'h8);
        wb(1'b0, CCR_ADDR_CTRL, 32'h0);
        check("div_reset", 32'(rd[2:0]), 32'(CCR_DIV_RST));
        wb(1'b1, CCR_ADDR_CTRL, 32'h3);
        wb(1'b0, CCR_ADDR_CTRL, 32'h0);
        check("div_rd", 32'(rd[2:0]), 32'h3);
        wb(1'b0, 4'h8, 32'h0);
        check("unmapped", rd, 32'h0);
        @(posedge i_clk);
        wait_for(o_cache2_clk, ~o_cache2_clk, 20);
        n = 0;
        wait_for(o_cache2_clk, ~o_cache2_clk, 20);
        for (n = 1; n < 20; n++) begin
            @(posedge i_clk);
            if (o_cache2_clk !== fb_out) break;
        end
        wait_for(o_dll_locked, 1'b1, 500);
        check("dll_lock", 32'(o_dll_locked), 32'h1);
        $display("test cache clock done");
    endtask
    task automatic test_period();
        int n;
        logic last;
        @(posedge i_clk);
        last = o_cache2_clk;
        wait_for(o_cache2_clk, ~last, 20);
        last = o_cache2_clk;
        for (n = 1; n < 20; n++) begin
            @(posedge i_clk);
            if (o_cache2_clk !== last) break;
        end
        check("half_period", 32'(n), 32'h3);
        check("fb_matches", 32'(fb_out), 32'(o_cache2_clk));
        $display("test period done");
    endtask
    task automatic test_ce();
        logic last;
        @(posedge i_clk);
        ce <= 1'b0;
        @(posedge i_clk);
        last = o_cache2_clk;
        repeat (8) @(posedge i_clk);
        check("ce_freeze", 32'(o_cache2_clk), 32'(last));
        ce <= 1'b1;
        $display("test clock enable done");
    endtask
    task automatic test_div_zero();
        wb(1'b1, CCR_ADDR_CTRL, 32'h0);
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        check("div0_clk", 32'(o_cache2_clk), 32'h0);
        repeat (6) @(posedge i_clk);
        check("div0_hold", 32'(o_cache2_clk), 32'h0);
        wb(1'b1, CCR_ADDR_CTRL, 32'h3);
        $display("test divisor zero done");
    endtask
    // Second hard reset in mid-run, strapped for the extended bus mode
    task automatic test_extended();
        @(posedge i_clk);
        ext_strap <= 1'b1;
        i_rst_b   <= 1'b0;
        act_a     <= 1'b1;
        act_d     <= 1'b0;
        repeat (3) @(posedge i_clk);
        i_rst_b <= 1'b1;
        @(negedge i_clk);
        check("mode_n_ext", 32'(o_mode_n), 32'h0);
        check("ext_mode_ext", 32'(o_extended_bus_mode), 32'h1);
        check("half_strap", 32'(o_core_half_mult), 32'(half_tab[code]));
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        check("half_held", 32'(o_core_half_mult), 32'(half_tab[code]));
        check("addr_bus_monitor", 32'(o_addr_bus_busy_n), 32'h0);
        check("data_bus_monitor", 32'(o_data_bus_busy_n), 32'h1);
        check("ext_oe_on", 32'(o_ext_only_oe), 32'h1);
        check("ext_out_on", 32'(o_ext_only_out), 32'h1);
        check("ext_in_on", 32'(o_ext_only_in_q), 32'h1);
        @(posedge i_clk);
        i_ext_only_in  <= 1'b0;
        i_ext_only_out <= 1'b0;
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        check("ext_in_off", 32'(o_ext_only_in_q), 32'h0);
        check("ext_out_off", 32'(o_ext_only_out), 32'h0);
        $display("test extended mode done");
    endtask
    task automatic test_pins();
        u_board.pulse_mcp(2);
        wait_for(o_machine_check, 1'b1, 5);
        check("mcheck", 32'(o_machine_check), 32'h1);
        i_addr_busy_n <= 1'b0;
        i_data_busy_n <= 1'b1;
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        check("abb", 32'(o_addr_bus_busy_n), 32'h0);
        check("dbb", 32'(o_data_bus_busy_n), 32'h1);
        check("busy_oe", 32'(o_busy_oe), 32'h1);
        check("ext_in_q", 32'(o_ext_only_in_q), 32'h0);
        check("ext_oe", 32'(o_ext_only_oe), 32'h0);
        check("ext_out", 32'(o_ext_only_out), 32'h0);
        check("mode_n", 32'(o_mode_n), 32'h1);
        check("ext_mode", 32'(o_extended_bus_mode), 32'h0);
        $display("test pins done");
    endtask
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    initial begin
        {i_rst_b, i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_sel, i_wb_dat} = '0;
        {i_addr_busy_n, i_data_busy_n, i_ext_only_in, i_ext_only_out} = 4'hf;
        {ce, ext_strap, act_a, act_d} = 4'h8;
        repeat (12) @(posedge i_clk);
        i_rst_b <= 1'b1;
        @(negedge i_clk);
        check("mode_n_rst", 32'(o_mode_n), 32'h1);
        check("half_rst", 32'(o_core_half_mult), 32'(half_tab[code]));
        @(negedge i_clk);
        check("half_rst_held", 32'(o_core_half_mult), 32'(half_tab[code]));
        test_codes();
        test_cache_clock();
        test_period();
        test_ce();
        test_div_zero();
        test_pins();
        test_extended();
        conclude();
    end
endmodule // core_clock_ratio_config_tb_top
